/* usbxc_ctrl.v */
`default_nettype none
`include "usbxc_consts.vh"
module usbxc_ctrl (
   input  wire       core_clk,
   input  wire       sys_rst,
   input  wire       clk_en,
   input  wire [7:0] sfr_addr,
   input  wire [7:0] sfr_wdata,
   input  wire       sfr_wr,
   input  wire       sfr_rd,
   output reg  [7:0] sfr_rdata,
   input  wire       vbus_present,
   input  wire       dplus_in,
   input  wire       dminus_in,
   input  wire       diff_rx_in,
   output reg        dplus_out,
   output reg        dplus_oe,
   output reg        dminus_out,
   output reg        dminus_oe,
   output reg        pullup_dplus,
   output reg        pullup_dminus,
   output reg        phy_enable,
   output reg        full_speed,
   output reg        host_mode,
   input  wire [2:0] pipe_sel,
   output reg  [7:0] pipe_proto_addr
);
   ////////////////////////////////////////////////////////////////////////
   reg        pullup_enable_q;
   reg        phy_enable_q;
   reg        speed_q;
   reg  [1:0] line_test_q;
   wire [2:0] line_sync;
   wire [7:0] ep_addr;
   wire       ep_valid;
   wire [7:0] status_word;
   wire       diff_receiver_state;
   wire       dplus_level;
   wire       dminus_level;

   usbxc_sync u_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .async_in ({diff_rx_in, dplus_in, dminus_in}),
      .sync_out (line_sync)
   );

   usbxc_ep_map u_ep_map (
      .pipe_sel   (pipe_sel),
      .proto_addr (ep_addr),
      .pipe_valid (ep_valid)
   );

   // receiver output is meaningless while suspended, so it reads zero
   assign diff_receiver_state = line_sync[2] & phy_enable_q;
   assign dplus_level         = line_sync[1];
   assign dminus_level        = line_sync[0];

   assign status_word = {pullup_enable_q, phy_enable_q, speed_q, line_test_q,
                         diff_receiver_state, dplus_level, dminus_level};

   ////////////////////////////////////////////////////////////////////////
   // register writes; read-only bits 2..0 ignore writes
   always @(posedge core_clk) begin
      if (sys_rst) begin
         pullup_enable_q <= 1'b0;
         phy_enable_q    <= 1'b0;
         speed_q         <= 1'b0;
         line_test_q     <= 2'h0;
      end else if (clk_en && sfr_wr && sfr_addr == `USBXC_CTRL_ADDR) begin
         pullup_enable_q <= sfr_wdata[`USBXC_PULLUP_EN_BIT];
         phy_enable_q    <= sfr_wdata[`USBXC_PHY_EN_BIT];
         speed_q         <= sfr_wdata[`USBXC_SPEED_BIT];
         line_test_q     <= {sfr_wdata[`USBXC_TEST_HI_BIT],
                             sfr_wdata[`USBXC_TEST_LO_BIT]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always @(posedge core_clk) begin
      if (sys_rst) begin
         sfr_rdata       <= 8'h00;
         dplus_out       <= 1'b0;
         dplus_oe        <= 1'b0;
         dminus_out      <= 1'b0;
         dminus_oe       <= 1'b0;
         pullup_dplus    <= 1'b0;
         pullup_dminus   <= 1'b0;
         phy_enable      <= 1'b0;
         full_speed      <= 1'b0;
         host_mode       <= 1'b0;
         pipe_proto_addr <= 8'h00;
      end else if (clk_en) begin
         // unmapped address reads zero
         if (sfr_rd && sfr_addr == `USBXC_CTRL_ADDR) begin
            sfr_rdata <= status_word;
         end else begin
            sfr_rdata <= 8'h00;
         end
         // attach only with bus power and enable set
         pullup_dplus  <= pullup_enable_q & vbus_present & speed_q;
         pullup_dminus <= pullup_enable_q & vbus_present & ~speed_q;
         phy_enable    <= phy_enable_q;
         full_speed    <= speed_q;
         host_mode     <= 1'b0;
         pipe_proto_addr <= ep_valid ? ep_addr : 8'h00;
         // forced line states drive the pins only in a test mode
         case (line_test_q)
            `USBXC_TEST_DIFF_ONE: begin
               dplus_out  <= 1'b1;
               dminus_out <= 1'b0;
               dplus_oe   <= 1'b1;
               dminus_oe  <= 1'b1;
            end
            `USBXC_TEST_DIFF_ZERO: begin
               dplus_out  <= 1'b0;
               dminus_out <= 1'b1;
               dplus_oe   <= 1'b1;
               dminus_oe  <= 1'b1;
            end
            `USBXC_TEST_SE0: begin
               dplus_out  <= 1'b0;
               dminus_out <= 1'b0;
               dplus_oe   <= 1'b1;
               dminus_oe  <= 1'b1;
            end
            default: begin
               dplus_out  <= 1'b0;
               dminus_out <= 1'b0;
               dplus_oe   <= 1'b0;
               dminus_oe  <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* usbxc_consts.vh */
`ifndef USBXC_CONSTS_VH
`define USBXC_CONSTS_VH
// register address and reset value
`define USBXC_CTRL_ADDR      8'hd7
`define USBXC_CTRL_RESET     8'h00
// field positions
`define USBXC_PULLUP_EN_BIT  7
`define USBXC_PHY_EN_BIT     6
`define USBXC_SPEED_BIT      5
`define USBXC_TEST_HI_BIT    4
`define USBXC_TEST_LO_BIT    3
`define USBXC_DIFF_BIT       2
`define USBXC_DPLUS_BIT      1
`define USBXC_DMINUS_BIT     0
// line test modes
`define USBXC_TEST_NORMAL    2'h0
`define USBXC_TEST_DIFF_ONE  2'h1
`define USBXC_TEST_DIFF_ZERO 2'h2
`define USBXC_TEST_SE0       2'h3
// endpoint protocol addresses
`define USBXC_EP0_ADDR       8'h00
`define USBXC_OUT_BASE       8'h00
`define USBXC_IN_BASE        8'h80
`define USBXC_EP_LAST        2'h3
`endif

/* usbxc_sync.v */
`default_nettype none
`include "usbxc_consts.vh"
module usbxc_sync (
   input  wire       core_clk,
   input  wire       sys_rst,
   input  wire       clk_en,
   input  wire [2:0] async_in,
   output reg  [2:0] sync_out
);
   reg [2:0] meta_q;
   // first stage feeds only the second stage
   always @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q   <= 3'h0;
         sync_out <= 3'h0;
      end else if (clk_en) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* usbxc_ep_map.v */
`default_nettype none
`include "usbxc_consts.vh"
module usbxc_ep_map (
   input  wire [2:0] pipe_sel,
   output reg  [7:0] proto_addr,
   output reg        pipe_valid
);
   // pipe_sel[2]=in direction, [1:0]=endpoint number
   always @* begin
      pipe_valid = 1'b1;
      if (pipe_sel[1:0] == 2'h0) begin
         proto_addr = `USBXC_EP0_ADDR;
      end else if (pipe_sel[2]) begin
         proto_addr = `USBXC_IN_BASE | {6'h00, pipe_sel[1:0]};
      end else begin
         proto_addr = `USBXC_OUT_BASE | {6'h00, pipe_sel[1:0]};
      end
   end
endmodule
`default_nettype wire

/* usbxc_ctrl_assertions.sv */
`default_nettype none
module usbxc_ctrl_assertions (
   input wire       core_clk,
   input wire       sys_rst,
   input wire       clk_en,
   input wire [7:0] sfr_addr,
   input wire [7:0] sfr_wdata,
   input wire       sfr_wr,
   input wire [7:0] sfr_rdata,
   input wire       vbus_present,
   input wire       dplus_oe,
   input wire       pullup_dplus,
   input wire       pullup_dminus,
   input wire       phy_enable,
   input wire       full_speed,
   input wire       host_mode,
   input wire [2:0] pipe_sel,
   input wire [7:0] pipe_proto_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   wire       wr_hit   = clk_en && sfr_wr && sfr_addr == 8'hd7;
   wire [1:0] wr_pf    = sfr_wdata[6:5];
   wire       wr_tst   = sfr_wdata[4:3] != 2'h0;
   wire [7:0] pipe_exp = {pipe_sel[2] & |pipe_sel[1:0], 5'h00, pipe_sel[1:0]};
   ////////////////////////////////////////
   // controls lag the write by two edges, so a second write right behind cannot disturb this
   a_host_never: assert property (!host_mode) else $error("host role");
   a_pullup_side: assert property (full_speed ? !pullup_dminus : !pullup_dplus)
      else $error("pull-up side");
   a_pullup_vbus: assert property ($past(clk_en) && !$past(vbus_present) |->
      !pullup_dplus && !pullup_dminus) else $error("pull-up without bus power");
   a_detach_clear: assert property (wr_hit && !sfr_wdata[7] ##1 clk_en |=>
      !pullup_dplus && !pullup_dminus) else $error("pull-up after detach");
   a_phy_follow: assert property (wr_hit ##1 clk_en |=>
      {phy_enable, full_speed} == $past(wr_pf, 2)) else $error("phy or speed");
   a_test_enter: assert property (wr_hit ##1 clk_en |=> dplus_oe == $past(wr_tst, 2))
      else $error("test drive");
   a_diff_gate: assert property (sfr_rdata[2] |-> sfr_rdata[6]) else $error("diff");
   a_pipe_map: assert property (clk_en |=> pipe_proto_addr == $past(pipe_exp))
      else $error("pipe address");
   c_force_se0: cover property (wr_hit && sfr_wdata[4:3] == 2'h3);
   c_low_attach: cover property (pullup_dminus);
   c_diff_seen: cover property (sfr_rdata[2]);
endmodule
`default_nettype wire

/* usbxc_host_model.sv */
`default_nettype none
module usbxc_host_model (
   input  wire  dplus_out,
   input  wire  dplus_oe,
   input  wire  dminus_out,
   input  wire  dminus_oe,
   input  wire  pullup_dplus,
   input  wire  pullup_dminus,
   output logic dplus_in,
   output logic dminus_in,
   output logic diff_rx_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // host pull-downs take a released line low; only the device pull-up lifts it
   assign dplus_in   = dplus_oe ? dplus_out : pullup_dplus;
   assign dminus_in  = dminus_oe ? dminus_out : pullup_dminus;
   assign diff_rx_in = dplus_in & !dminus_in;
endmodule
`default_nettype wire

/* usbxc_ctrl_tb.sv */
`default_nettype none
module usbxc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       core_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0;
   logic       vbus_present = 1'h0, dplus_in, dminus_in, diff_rx_in, dplus_out, dplus_oe;
   logic       dminus_out, dminus_oe, pullup_dplus, pullup_dminus, phy_enable, full_speed;
   logic       host_mode, pd, pm, ed, em;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, pipe_proto_addr, q, e;
   logic [2:0] pipe_sel = 3'h0;
   int         err_count = 0, total_checks = 0;
   usbxc_ctrl       u_dut (.*);
   usbxc_host_model u_host (.*);
   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // five idle cycles cover control latency plus the status synchronizer
   task automatic acc(input logic [1:0] wr_rd, input logic [7:0] a, d);
      {sfr_wr, sfr_rd} = wr_rd;
      sfr_addr = a;
      sfr_wdata = d;
      @(negedge core_clk);
      {sfr_wr, sfr_rd} = 2'h0;
      q = sfr_rdata;
      repeat (5) @(negedge core_clk);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (2) @(negedge core_clk);
      sys_rst = 1'h0;
      acc(2'h1, 8'hd7, 8'h00);
      chk(q, 8'h00);
      for (int i = 0; i < 64; i++) begin
         vbus_present = i[5];
         acc(2'h2, 8'hd7, {i[4:0], 3'h7});
         acc(2'h1, 8'hd7, 8'h00);
         pd = i[4] & i[5] & i[2];
         pm = i[4] & i[5] & !i[2];
         ed = i[1:0] == 2'h0 ? pd : i[1:0] == 2'h1;
         em = i[1:0] == 2'h0 ? pm : i[1:0] == 2'h2;
         chk(q, {i[4:0], i[3] & ed & !em, ed, em});
         e = {5'h00, i[1:0] != 2'h0, i[1:0] != 2'h0, i[1:0] == 2'h1};
         chk({4'h0, pullup_dplus, pullup_dminus, phy_enable, full_speed}, {4'h0, pd, pm, i[3:2]});
         chk({4'h0, host_mode, dplus_oe, dminus_oe, dplus_out}, e);
      end
      acc(2'h2, 8'hd6, 8'hff);
      acc(2'h1, 8'hd6, 8'h00);
      chk(q, 8'h00);
      clk_en = 1'h0;
      acc(2'h2, 8'hd7, 8'h00);
      clk_en = 1'h1;
      acc(2'h1, 8'hd7, 8'h00);
      chk(q, 8'hf8);
      for (int s = 0; s < 8; s++) begin
         pipe_sel = s[2:0];
         @(negedge core_clk);
         chk(pipe_proto_addr, {s[2] & |s[1:0], 5'h00, s[1:0]});
      end
      final_report();
   end
endmodule
bind usbxc_ctrl usbxc_ctrl_assertions u_chk (.*);
`default_nettype wire
